// >>> common/twi_pkg.sv
// Purpose: shared constants for the two-wire memory link, both ends
// Assumes: 250 MHz system clock on both ends
// Notes: timing counts derive from the printed times and the clock rate
package twi_pkg;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 4;
	localparam int SCL_PERIOD_NS = 160;
	// Quarter of a serial clock period in system cycles
	localparam int QTR_CYC = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
	localparam int PROG_TIME_MS = 5;
	// Longest time, so rounded down
	localparam int PROG_CYC = PROG_TIME_MS * 1000000 / CLK_PERIOD_NS;

	// ----------------------------------------
	// Memory shape and addressing
	// ----------------------------------------
	localparam int ADDR_W = 8;
	localparam int PAGE_BYTES = 16;
	localparam int COL_W = 4;
	localparam logic [7:0] ERASED_BYTE = 8'hff;
	// Device type nibble; arbitrary value
	localparam logic [3:0] DEV_TYPE_DEFAULT = 4'h6;

	// ----------------------------------------
	// Controller registers
	// ----------------------------------------
	localparam logic [3:0] CTRL_OFS = 4'h0;
	localparam logic [3:0] STAT_OFS = 4'h4;
	localparam int CTRL_PRIM_LSB = 0;
	localparam int CTRL_ACK_BIT = 2;
	localparam int CTRL_TX_LSB = 8;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_ACK_BIT = 1;
	localparam int STAT_RX_LSB = 8;

	typedef enum logic [1:0] {
		PRIM_START = 2'b00,
		PRIM_STOP = 2'b01,
		PRIM_WRITE = 2'b10,
		PRIM_READ = 2'b11
	} prim_e;
endpackage : twi_pkg

// >>> common/twi_link_if.sv
// Purpose: two-wire link between controller and memory end
// Assumes: data line pulled high, clock driven by the controller only
// Notes: the wire level is worked out here from both enables
`timescale 1ns/1ps
`default_nettype none
interface twi_link_if;
	logic scl;
	logic m_sda_o;
	logic m_sda_oe_n;
	logic d_sda_o;
	logic d_sda_oe_n;
	logic sda;

	// Wired-AND with pull-up
	assign sda = (m_sda_oe_n | m_sda_o) & (d_sda_oe_n | d_sda_o);

	modport master (output scl, output m_sda_o, output m_sda_oe_n, input sda);
	modport device (input scl, input sda, output d_sda_o, output d_sda_oe_n);
endinterface : twi_link_if
`default_nettype wire

// >>> rtl/twi_mem_dev.sv
// Purpose: memory end of the two-wire link, 256 bytes with page writes
// Assumes: straps and protect pin are static levels; unconnected means low
// Notes: link lines are oversampled by clk; contents erased at reset
`timescale 1ns/1ps
`default_nettype none
module twi_mem_dev
	import twi_pkg::*;
#(
	parameter int PROG_CYCLES = PROG_CYC,
	parameter logic [3:0] DEV_TYPE = DEV_TYPE_DEFAULT
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic chip_select_strap_high,
	input wire logic chip_select_strap_mid,
	input wire logic chip_select_strap_low,
	input wire logic write_protect,
	output logic standby,
	output logic programming,
	twi_link_if.device link
);
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_DEV = 3'b001,
		ST_WORD = 3'b010,
		ST_WDATA = 3'b011,
		ST_RDATA = 3'b100,
		ST_PROG = 3'b101
	} dev_state_e;

	// ----------------------------------------
	// Input synchronisers and edge detection
	// ----------------------------------------
	logic [5:0] pin_m_q;
	logic [5:0] pin_s_q;
	logic scl_p_q;
	logic sda_p_q;

	// Two flops for every outside level, then one more for edges
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pin_m_q <= 6'h30; // Lines idle high, so no false edge after reset
			pin_s_q <= 6'h30;
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
		end else if (ce) begin
			pin_m_q <= {link.scl, link.sda, chip_select_strap_high, chip_select_strap_mid,
				chip_select_strap_low, write_protect};
			pin_s_q <= pin_m_q;
			scl_p_q <= pin_s_q[5];
			sda_p_q <= pin_s_q[4];
		end
	end

	logic scl_s;
	logic sda_s;
	logic [2:0] straps_s;
	logic wp_s;
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;
	assign scl_s = pin_s_q[5];
	assign sda_s = pin_s_q[4];
	assign straps_s = pin_s_q[3:1];
	assign wp_s = pin_s_q[0];
	assign scl_rise = scl_s & ~scl_p_q;
	assign scl_fall = ~scl_s & scl_p_q;
	assign start_det = scl_s & scl_p_q & sda_p_q & ~sda_s;
	assign stop_det = scl_s & scl_p_q & ~sda_p_q & sda_s;

	// ----------------------------------------
	// Protocol engine
	// ----------------------------------------
	dev_state_e state_q;
	logic [3:0] bit_cnt_q;
	logic ack_phase_q;
	logic [7:0] shift_q;
	logic [7:0] tx_q;
	logic mack_q;
	logic [ADDR_W-1:0] addr_q;
	logic pull_q;
	logic [7:0] mem_q [0:(1 << ADDR_W)-1];
	logic [7:0] page_q [0:PAGE_BYTES-1];
	logic [PAGE_BYTES-1:0] page_mask_q;
	logic [ADDR_W-COL_W-1:0] page_row_q;
	logic [22:0] prog_cnt_q;
	logic dev_match;

	// Address word checks: type nibble, straps, direction in bit 0
	assign dev_match = (shift_q[7:4] == DEV_TYPE) && (shift_q[3:1] == straps_s);

	// State, bit counting, acknowledge and serial output
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_q <= ST_IDLE;
			bit_cnt_q <= 4'h0;
			ack_phase_q <= 1'b0;
			shift_q <= 8'h00;
			tx_q <= 8'h00;
			mack_q <= 1'b0;
			pull_q <= 1'b0;
		end else if (ce) begin
			if (state_q == ST_PROG) begin
				// Link ignored, so address words go unacknowledged
				pull_q <= 1'b0;
				if (prog_cnt_q == 23'(PROG_CYCLES - 1)) begin
					state_q <= ST_IDLE;
				end
			end else if (start_det) begin
				// Any START outside programming aborts the current command, also mid-byte
				state_q <= ST_DEV;
				bit_cnt_q <= 4'h0;
				ack_phase_q <= 1'b0;
				pull_q <= 1'b0;
			end else if (stop_det) begin
				pull_q <= 1'b0;
				ack_phase_q <= 1'b0;
				if (state_q == ST_WDATA && page_mask_q != '0 && !wp_s) begin
					state_q <= ST_PROG;
				end else begin
					state_q <= ST_IDLE;
				end
			end else if (state_q != ST_IDLE) begin
				if (scl_rise) begin
					if (!ack_phase_q && bit_cnt_q != 4'h8) begin
						shift_q <= {shift_q[6:0], sda_s};
						bit_cnt_q <= bit_cnt_q + 4'h1;
					end else if (ack_phase_q && state_q == ST_RDATA) begin
						mack_q <= ~sda_s;
					end
				end else if (scl_fall) begin
					if (bit_cnt_q == 4'h8 && !ack_phase_q) begin
						ack_phase_q <= 1'b1;
						case (state_q)
							ST_DEV: begin
								if (dev_match) begin
									pull_q <= 1'b1;
									mack_q <= 1'b1;
									state_q <= shift_q[0] ? ST_RDATA : ST_WORD;
								end else begin
									state_q <= ST_IDLE;
								end
							end
							ST_WORD: begin
								pull_q <= 1'b1;
								state_q <= ST_WDATA;
							end
							ST_WDATA: begin
								pull_q <= 1'b1;
							end
							default: begin
								pull_q <= 1'b0; // Master answers the read byte
							end
						endcase
					end else if (ack_phase_q) begin
						ack_phase_q <= 1'b0;
						bit_cnt_q <= 4'h0;
						pull_q <= 1'b0;
						if (state_q == ST_RDATA) begin
							if (mack_q) begin
								tx_q <= mem_q[addr_q];
								pull_q <= ~mem_q[addr_q][7];
							end else begin
								state_q <= ST_IDLE;
							end
						end
					end else if (state_q == ST_RDATA && bit_cnt_q != 4'h0) begin
						pull_q <= ~tx_q[3'(4'h7 - bit_cnt_q)];
					end
				end
			end
		end
	end

	// Address counter: word load, page column wrap, read increment
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			addr_q <= '0;
		end else if (ce && state_q != ST_PROG && !start_det && !stop_det && scl_fall) begin
			if (bit_cnt_q == 4'h8 && !ack_phase_q && state_q == ST_WORD) begin
				addr_q <= shift_q;
			end else if (bit_cnt_q == 4'h8 && !ack_phase_q && state_q == ST_WDATA) begin
				addr_q <= {addr_q[ADDR_W-1:COL_W], addr_q[COL_W-1:0] + 4'h1};
			end else if (ack_phase_q && state_q == ST_RDATA && mack_q) begin
				addr_q <= addr_q + 8'h01;
			end
		end
	end

	// Page latch fills during the write; array changes only at the end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			page_mask_q <= '0;
			page_row_q <= '0;
			for (int i = 0; i < PAGE_BYTES; i++) begin
				page_q[i] <= 8'h00;
			end
		end else if (ce && state_q != ST_PROG && !start_det && !stop_det && scl_fall
			&& bit_cnt_q == 4'h8 && !ack_phase_q) begin
			if (state_q == ST_WORD) begin
				page_mask_q <= '0;
			end else if (state_q == ST_WDATA) begin
				page_q[addr_q[COL_W-1:0]] <= shift_q;
				page_mask_q[addr_q[COL_W-1:0]] <= 1'b1;
				page_row_q <= addr_q[ADDR_W-1:COL_W];
			end
		end
	end

	// Self-timed programming; the array is written on the last count
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			prog_cnt_q <= '0;
			for (int i = 0; i < (1 << ADDR_W); i++) begin
				mem_q[i] <= ERASED_BYTE;
			end
		end else if (ce) begin
			if (state_q != ST_PROG) begin
				prog_cnt_q <= '0;
			end else begin
				prog_cnt_q <= prog_cnt_q + 23'h1;
				if (prog_cnt_q == 23'(PROG_CYCLES - 1)) begin
					for (int c = 0; c < PAGE_BYTES; c++) begin
						if (page_mask_q[c]) begin
							mem_q[{page_row_q, 4'(c)}] <= page_q[c];
						end
					end
				end
			end
		end
	end

	// ----------------------------------------
	// Outputs from flops, except the data level tied low
	// ----------------------------------------
	logic sda_oe_n_q;
	logic standby_q;
	logic prog_q;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sda_oe_n_q <= 1'b1;
			standby_q <= 1'b1;
			prog_q <= 1'b0;
		end else if (ce) begin
			sda_oe_n_q <= ~pull_q;
			standby_q <= (state_q == ST_IDLE);
			prog_q <= (state_q == ST_PROG);
		end
	end
	assign link.d_sda_oe_n = sda_oe_n_q;
	assign link.d_sda_o = 1'b0; // Only ever pulls low
	assign standby = standby_q;
	assign programming = prog_q;
endmodule : twi_mem_dev
`default_nettype wire

// >>> rtl/twi_ctrl.sv
// Purpose: bus-master end; runs START, STOP, byte write, byte read
// Assumes: software sequences primitives over Avalon-MM
// Notes: serial clock made by dividing clk into quarter periods
`timescale 1ns/1ps
`default_nettype none
module twi_ctrl
	import twi_pkg::*;
#(
	parameter int QTR_CYCLES = QTR_CYC
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic [3:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	output logic [31:0] readdata,
	output logic waitrequest,
	twi_link_if.master link
);
	typedef enum logic {M_IDLE = 1'b0, M_RUN = 1'b1} ctrl_state_e;

	// Pin levels {scl, sda} for one quarter of a primitive
	function automatic logic [1:0] pins(input prim_e p, input logic [1:0] q, input logic b);
		logic [1:0] r;
		r = {(q == 2'd1 || q == 2'd2), b};
		case (p)
			PRIM_START: r = {(q == 2'd1 || q == 2'd2), (q < 2'd2)};
			PRIM_STOP: r = {(q != 2'd0), (q >= 2'd2)};
			default: r = {(q == 2'd1 || q == 2'd2), b};
		endcase
		return r;
	endfunction : pins

	// ----------------------------------------
	// Synchroniser for the data line
	// ----------------------------------------
	logic sda_m_q;
	logic sda_s_q;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sda_m_q <= 1'b1;
			sda_s_q <= 1'b1;
		end else if (ce) begin
			sda_m_q <= link.sda;
			sda_s_q <= sda_m_q;
		end
	end

	// ----------------------------------------
	// Register slave and bit sequencer
	// ----------------------------------------
	ctrl_state_e state_q;
	prim_e prim_q;
	logic ack_send_q;
	logic [7:0] tx_q;
	logic [7:0] rx_q;
	logic ack_rx_q;
	logic [1:0] qtr_q;
	logic [3:0] bit_q;
	logic [7:0] div_q;
	logic scl_q;
	logic sda_oe_n_q;
	logic wait_q;
	logic [31:0] rdata_q;
	logic launch;
	logic last_bit;
	logic tx_bit;
	logic [1:0] nq;
	logic [1:0] np;
	logic [3:0] nb;

	assign launch = write && !wait_q && address == CTRL_OFS;
	// Bit of the coming quarter, so data moves in the low quarter, not at the rise
	assign nb = (qtr_q == 2'd3) ? bit_q + 4'h1 : bit_q;
	assign last_bit = (prim_q == PRIM_START || prim_q == PRIM_STOP || bit_q == 4'h8);
	// Read bytes release the line; the ninth bit carries the ack choice
	assign tx_bit = (nb == 4'h8) ? (prim_q == PRIM_READ ? ~ack_send_q : 1'b1)
		: (prim_q == PRIM_READ ? 1'b1 : tx_q[3'(4'h7 - nb)]);
	assign nq = qtr_q + 2'd1;
	assign np = pins(prim_q, (qtr_q == 2'd3) ? 2'd0 : nq, tx_bit);

	// Bus handshake: one cycle of waitrequest low per request
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wait_q <= 1'b1;
			rdata_q <= '0;
		end else if (ce) begin
			if (!wait_q) begin
				wait_q <= 1'b1;
			end else if (read) begin
				wait_q <= 1'b0;
				rdata_q <= (address == STAT_OFS) ? {16'h0000, rx_q, 6'h00, ack_rx_q,
					state_q == M_RUN} : 32'h0000_0000;
			end else if (write && (state_q == M_IDLE || address != CTRL_OFS)) begin
				wait_q <= 1'b0; // Stalls a new primitive while busy
			end
		end
	end

	// Primitive sequencing in quarter periods
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_q <= M_IDLE;
			prim_q <= PRIM_STOP;
			ack_send_q <= 1'b0;
			tx_q <= 8'h00;
			rx_q <= 8'h00;
			ack_rx_q <= 1'b0;
			qtr_q <= 2'd0;
			bit_q <= 4'h0;
			div_q <= 8'h00;
			scl_q <= 1'b1;
			sda_oe_n_q <= 1'b1;
		end else if (ce) begin
			if (launch) begin
				state_q <= M_RUN;
				prim_q <= prim_e'(writedata[CTRL_PRIM_LSB +: 2]);
				ack_send_q <= writedata[CTRL_ACK_BIT];
				tx_q <= writedata[CTRL_TX_LSB +: 8];
				qtr_q <= 2'd0;
				bit_q <= 4'h0;
				div_q <= 8'h00;
				{scl_q, sda_oe_n_q} <= pins(prim_e'(writedata[CTRL_PRIM_LSB +: 2]), 2'd0,
					writedata[CTRL_PRIM_LSB +: 2] == PRIM_READ ? 1'b1
					: writedata[CTRL_TX_LSB + 7]);
			end else if (state_q == M_RUN) begin
				div_q <= div_q + 8'h01;
				if (div_q == 8'(QTR_CYCLES - 1)) begin
					div_q <= 8'h00;
					// Sample while the clock is high, at the end of its second high quarter
					if (qtr_q == 2'd2 && (prim_q == PRIM_WRITE || prim_q == PRIM_READ)) begin
						if (bit_q == 4'h8) begin
							ack_rx_q <= ~sda_s_q;
						end else begin
							rx_q <= {rx_q[6:0], sda_s_q};
						end
					end
					if (qtr_q == 2'd3 && last_bit) begin
						state_q <= M_IDLE;
					end else begin
						qtr_q <= nq;
						if (qtr_q == 2'd3) begin
							bit_q <= bit_q + 4'h1;
						end
						{scl_q, sda_oe_n_q} <= np;
					end
				end
			end
		end
	end

	assign link.scl = scl_q;
	assign link.m_sda_oe_n = sda_oe_n_q;
	assign link.m_sda_o = 1'b0;
	assign readdata = rdata_q;
	assign waitrequest = wait_q;
endmodule : twi_ctrl
`default_nettype wire

// >>> tb/twi_link_monitor.sv
// Purpose: wire-level checks beside the link between the two ends
// Assumes: sda is the resolved wire level
// Notes: PROG_CYCLES must match the memory end instance
`timescale 1ns/1ps
`default_nettype none
module twi_link_monitor #(
	parameter int PROG_CYCLES = 1000
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic scl,
	input wire logic sda,
	input wire logic d_sda_o,
	input wire logic d_sda_oe_n,
	input wire logic standby,
	input wire logic programming
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	// ----------------------------------------
	// Helper: length of the running programming spell
	// ----------------------------------------
	int prog_cnt_q;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			prog_cnt_q <= 0;
		end else begin
			prog_cnt_q <= programming ? prog_cnt_q + 1 : 0;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	a_sda_open_drain: assert property (d_sda_o == 1'b0)
		else $error("memory end drives data line high");
	// Synchroniser delay means scl has been low a while before a pull
	a_pull_scl_low: assert property ($fell(d_sda_oe_n) |-> !scl && !$past(scl, 2))
		else $error("data pulled low outside clock low");
	a_release_scl_low: assert property ($rose(d_sda_oe_n) |-> !scl)
		else $error("data released while clock high");
	a_prog_after_stop: assert property ($rose(programming) |-> scl && sda)
		else $error("programming began without a stop");
	a_prog_bounded: assert property (prog_cnt_q <= PROG_CYCLES + 1)
		else $error("programming ran too long");
	a_prog_no_ack: assert property (programming |-> d_sda_oe_n)
		else $error("line driven during programming");
	a_prog_not_idle: assert property (programming |-> !standby)
		else $error("standby during programming");
	a_prog_to_idle: assert property ($fell(programming) |-> ##[0:4] standby)
		else $error("no standby after programming");
	a_stop_idles: assert property (scl && $rose(sda) |-> ##[1:8] (standby || programming))
		else $error("stop left the memory end busy");
	a_start_wakes: assert property (scl && $fell(sda) && !programming |-> ##[1:8] !standby)
		else $error("start not recognised");

	c_program: cover property ($rose(programming));
	c_ack: cover property ($fell(d_sda_oe_n));
	c_stop_idle: cover property (scl && $rose(sda) ##[1:8] standby);
endmodule : twi_link_monitor
`default_nettype wire

// >>> tb/tb.sv
// Purpose: self-checking bench, controller joined to memory end
// Assumes: straps and protect pin are driven by the bench
// Notes: short programming time keeps the run brief
`timescale 1ns/1ps
`default_nettype none
module tb
	import twi_pkg::*;
;
	localparam int PROG_SIM = 1000;
	logic clk, rst, rd, wr, wp, ak;
	logic [3:0] adr;
	logic [31:0] wdat, rdat, st, seed, r32;
	logic waitrequest, standby, programming;
	logic [2:0] cs;
	logic [7:0] mem [256];
	int failures, samples_checked, n;

	twi_link_if link();
	twi_ctrl i_twi_ctrl (.clk(clk), .rst(rst), .ce(1'b1), .address(adr), .read(rd),
		.write(wr), .writedata(wdat), .readdata(rdat), .waitrequest(waitrequest), .link(link));
	twi_mem_dev #(.PROG_CYCLES(PROG_SIM)) i_twi_mem_dev (.clk(clk), .rst(rst), .ce(1'b1),
		.chip_select_strap_high(cs[2]), .chip_select_strap_mid(cs[1]),
		.chip_select_strap_low(cs[0]), .write_protect(wp), .standby(standby),
		.programming(programming), .link(link));
	twi_link_monitor #(.PROG_CYCLES(PROG_SIM)) i_twi_link_monitor (.clk(clk), .rst(rst),
		.scl(link.scl), .sda(link.sda), .d_sda_o(link.d_sda_o),
		.d_sda_oe_n(link.d_sda_oe_n), .standby(standby), .programming(programming));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xs

	// Expected address of the i-th byte of a page write; column wraps in the row
	function logic [7:0] page_addr(input logic [7:0] a0, input int i);
		return {a0[7:4], a0[3:0] + 4'(i)};
	endfunction : page_addr

	task chk_bit(input logic got, input logic exp);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("BAD %0t bit %b want %b", $time, got, exp);
		end
	endtask : chk_bit

	task chk_byte(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("BAD %0t byte %h want %h", $time, got, exp);
		end
	endtask : chk_byte

	// One bus cycle; request held until waitrequest is seen low
	task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clk);
		adr <= a;
		wdat <= d;
		wr <= w;
		rd <= !w;
		do begin
			@(posedge clk);
			k++;
		end while (waitrequest !== 1'b0 && k < 1000);
		if (k >= 1000) begin
			failures++;
			$display("BAD %0t no bus answer", $time);
		end
		st = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask : bus

	// Busy polling avoids assuming any primitive length
	task prim(input prim_e p, input logic [7:0] tx, input logic more);
		int k;
		k = 0;
		bus(1'b1, CTRL_OFS, {16'h0, tx, 5'h0, more, p});
		do begin
			bus(1'b0, STAT_OFS, 32'h0);
			k++;
		end while (st[STAT_BUSY_BIT] !== 1'b0 && k < 1000);
		if (k >= 1000) begin
			failures++;
			$display("BAD %0t primitive never finished", $time);
		end
	endtask : prim

	task wbyte(input logic [7:0] b, output logic a);
		prim(PRIM_WRITE, b, 1'b0);
		a = st[STAT_ACK_BIT];
	endtask : wbyte

	task cmd(input logic [2:0] c, input logic r, output logic a);
		prim(PRIM_START, 8'h00, 1'b0);
		wbyte({DEV_TYPE_DEFAULT, c, r}, a);
	endtask : cmd

	task stop();
		prim(PRIM_STOP, 8'h00, 1'b0);
	endtask : stop

	// Random read of cnt bytes from a0 via dummy write
	task rd_seq(input logic [7:0] a0, input int cnt);
		logic a;
		cmd(cs, 1'b0, a);
		chk_bit(a, 1'b1);
		wbyte(a0, a);
		cmd(cs, 1'b1, a);
		chk_bit(a, 1'b1);
		for (int i = 0; i < cnt; i++) begin
			prim(PRIM_READ, 8'h00, i < cnt - 1);
			chk_byte(st[STAT_RX_LSB +: 8], mem[a0 + 8'(i)]);
		end
		stop();
	endtask : rd_seq

	// Page write of cnt random bytes; model follows the column wrap
	task wr_page(input logic [7:0] a0, input int cnt);
		logic a;
		logic [7:0] d;
		cmd(cs, 1'b0, a);
		wbyte(a0, a);
		for (int i = 0; i < cnt; i++) begin
			r32 = xs();
			d = r32[7:0];
			wbyte(d, a);
			chk_bit(a, 1'b1);
			if (!wp) mem[page_addr(a0, i)] = d;
		end
		stop();
	endtask : wr_page

	// Address polling until the memory end answers again
	task ack_poll(output int k);
		k = 0;
		cmd(cs, 1'b0, ak);
		while (ak !== 1'b1 && k < 20) begin
			stop();
			cmd(cs, 1'b0, ak);
			k++;
		end
		chk_bit(ak, 1'b1);
		stop();
	endtask : ack_poll

	task results();
		$display("checks %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : results

	// ----------------------------------------
	// Clock and watchdog
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	initial begin
		repeat (100000) @(posedge clk);
		failures++;
		$display("BAD %0t watchdog expired", $time);
		results();
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		rst = 1'b1;
		{rd, wr, wp, adr, wdat} = '0;
		failures = 0;
		samples_checked = 0;
		seed = 32'd71665;
		r32 = xs();
		cs = r32[2:0];
		for (int i = 0; i < 256; i++) mem[i] = ERASED_BYTE;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		chk_bit(standby, 1'b1);
		chk_bit(programming, 1'b0);
		// Wrong strap, then wrong type nibble
		cmd(cs ^ 3'h4, 1'b0, ak);
		chk_bit(ak, 1'b0);
		chk_bit(standby, 1'b1);
		stop();
		prim(PRIM_START, 8'h00, 1'b0);
		wbyte({DEV_TYPE_DEFAULT ^ 4'h1, cs, 1'b0}, ak);
		chk_bit(ak, 1'b0);
		stop();
		// Over-full page in the top row, then polling
		r32 = xs();
		wr_page({4'hf, r32[3:0]}, 17);
		ack_poll(n);
		chk_bit(n > 0, 1'b1);
		// Reads under protection, across the top of the array
		wp <= 1'b1;
		rd_seq(8'hf0, 18);
		cmd(cs, 1'b1, ak);
		prim(PRIM_READ, 8'h00, 1'b0);
		chk_byte(st[STAT_RX_LSB +: 8], mem[8'h02]);
		stop();
		// Protected write must not program
		wr_page(8'h05, 1);
		chk_bit(programming, 1'b0);
		rd_seq(8'h05, 1);
		// Partial page, unprotected
		wp <= 1'b0;
		r32 = xs();
		wr_page({4'h2, r32[3:0]}, 3);
		ack_poll(n);
		rd_seq(8'h20, 16);
		// Interrupted write, then recovery sequence
		cmd(cs, 1'b0, ak);
		wbyte(8'h33, ak);
		prim(PRIM_START, 8'h00, 1'b0);
		wbyte(8'hff, ak);
		wbyte(8'hff, ak);
		prim(PRIM_START, 8'h00, 1'b0);
		stop();
		chk_bit(standby, 1'b1);
		rd_seq(8'h00, 2);
		results();
	end
endmodule : tb
`default_nettype wire
